/* File: core/gcr_pkg.sv */
package gcr_pkg;

	// indirect register numbers
	localparam logic [7:0] GCR_ADDR_CMD_CTRL  = 8'h02;
	localparam logic [7:0] GCR_ADDR_OP_MODE   = 8'h04;
	localparam logic [7:0] GCR_ADDR_DISP_CTRL = 8'h06;

	localparam logic [15:0] GCR_CMD_CTRL_RESET = 16'h8000;
	localparam logic [1:0]  GCR_OP_MODE_TOP_RESET = 2'h0;

	// access mode codes
	localparam logic [1:0] GCR_ACM_INTERLEAVE = 2'h2;
	// scan mode codes
	localparam logic [1:0] GCR_RSM_INTERLACE_SV = 2'h3;
	// pixel depth code for eight bits per pixel
	localparam logic [2:0] GCR_DEPTH_8BPP = 3'h3;
	// display address increment code for four words
	localparam logic [2:0] GCR_GAI_PLUS4 = 3'h2;
	localparam logic [2:0] GCR_GAI_STEP4 = 3'h4;

	typedef struct packed {
		logic       abort_bit;
		logic       pause_bit;
		logic       data_dma_mode;
		logic       command_dma_mode;
		logic       dma_request_control;
		logic [2:0] pixel_depth_select;
		logic       command_error_irq_en;
		logic       area_detect_irq_en;
		logic       command_end_irq_en;
		logic       light_pen_irq_en;
		logic       read_queue_full_irq_en;
		logic       read_queue_ready_irq_en;
		logic       write_queue_ready_irq_en;
		logic       write_queue_empty_irq_en;
	} gcr_cmd_ctrl_t;

	typedef struct packed {
		logic       master_mode;
		logic       run_bit;
		logic       access_priority;
		logic       window_smooth_scroll;
		logic [1:0] cursor_skew;
		logic [1:0] blank_skew;
		logic       static_ram_mode;
		logic [2:0] display_addr_increment;
		logic [1:0] access_mode_select;
		logic [1:0] scan_mode_select;
	} gcr_op_mode_t;

	typedef struct packed {
		logic       combined_blanking;
		logic       base_screen_enable;
		logic [1:0] upper_screen_enable;
		logic [1:0] lower_screen_enable;
		logic [1:0] window_screen_enable;
		logic [7:0] user_attribute_byte;
	} gcr_disp_ctrl_t;

	// register-bus request from the host side
	typedef struct packed {
		logic        addr_wr;
		logic        data_wr;
		logic        data_rd;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} gcr_host_req_t;

	typedef struct packed {
		logic       cmd_run;
		logic       draw_run;
		logic       display_run;
		logic       data_dma;
		logic       command_dma;
		logic       dma_req_en;
		logic [7:0] irq_en;
		logic [2:0] pixel_bits;
		logic [2:0] addr_step;
		logic       interleave;
		logic       interlace_sv;
		logic       refresh_en;
		logic       crosshair_ok;
		logic       window_prefetch;
		logic       display_first;
		logic       master_timing;
		logic [3:0] screen_on;
	} gcr_ctrl_t;

endpackage

/* File: core/gcr_control_regs.sv */
`timescale 1ns/1ps
// Behaviour
// - command control resets to 8000 hex
// - low command bits enable interrupt sources
// - bits 10..8 select pixel depth
// - bits 13..11 control DMA modes
// - pause bit halts command execution
// - abort set by reset blocks commands
// - reset clears only operation mode top bits
// - bits 1..0 select raster scan mode
// - bits 3..2 select frame buffer access
// - increment code 2 steps four words
// - RAM bit clear enables DRAM refresh
// - skew fields delay blanking and cursor
// - zero cursor skew forbids cross hair
// - smooth scroll bit enables window prefetch
// - priority zero favours display over drawing
// - start bit gates drawing and display
// - master bit selects internal display timing
// - attribute byte output during horizontal flyback
// - split-screen enables per screen
// - blanking control selects display enable usage
module gcr_control_regs
	import gcr_pkg::*;
(
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire gcr_host_req_t host_req_i,
	input  wire logic          hblank_i,
	input  wire logic          vblank_i,
	input  wire logic          window_active_i,
	input  wire logic          cursor_a_i,
	input  wire logic          cursor_b_i,
	output logic [15:0]        rdata_o,
	output gcr_ctrl_t          ctrl_o,
	output logic [7:0]         attribute_o,
	output logic               display_enable_out_a_o,
	output logic               display_enable_out_b_o,
	output logic               cursor_out_a_o,
	output logic               cursor_out_b_o
);

	logic [7:0]     addr_ptr;
	gcr_cmd_ctrl_t  cmd_ctrl;
	gcr_op_mode_t   op_mode;
	gcr_disp_ctrl_t disp_ctrl;
	logic [1:0]     op_top;
	logic [13:0]    op_low;
	logic           wr_cmd;
	logic           wr_op;
	logic           wr_disp;
	// decoded controls, one per concern
	logic           cmd_allowed;
	logic           engines_run;
	logic [7:0]     irq_sources;
	logic [2:0]     dma_modes;
	logic [2:0]     step_words;
	logic           dram_refresh;
	logic           crosshair_allowed;
	logic [3:0]     screens_on;
	// union of the blanking inputs and skewed copies of the timing inputs
	logic           blank_now;
	logic           blank_tap;
	logic           win_tap;
	logic           curs_a_tap;
	logic           curs_b_tap;

	// the pointer never auto-increments, so a write lands where the host last aimed it
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			addr_ptr <= 8'h00;
		end else if (host_req_i.addr_wr) begin
			addr_ptr <= host_req_i.addr;
		end
	end

	// write strobe for command control
	assign wr_cmd  = host_req_i.data_wr && (addr_ptr == GCR_ADDR_CMD_CTRL);
	// write strobe for operation mode
	assign wr_op   = host_req_i.data_wr && (addr_ptr == GCR_ADDR_OP_MODE);
	// write strobe for display control
	assign wr_disp = host_req_i.data_wr && (addr_ptr == GCR_ADDR_DISP_CTRL);

	// command control: abort set, everything else clear after reset
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cmd_ctrl <= gcr_cmd_ctrl_t'(GCR_CMD_CTRL_RESET);
		end else if (wr_cmd) begin
			cmd_ctrl <= gcr_cmd_ctrl_t'(host_req_i.wdata);
		end
	end

	// operation mode top bits: master and start are cleared by reset
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			op_top <= GCR_OP_MODE_TOP_RESET;
		end else if (wr_op) begin
			op_top <= host_req_i.wdata[15:14];
		end
	end

	// no reset here: reset leaves these fourteen bits unchanged,
	// so they power up unknown until the host first writes them
	always_ff @(posedge clk_i) begin
		if (wr_op && !rst_i) begin
			op_low <= host_req_i.wdata[13:0];
		end
	end

	// the two halves are kept apart so each has a single driving process
	assign op_mode = gcr_op_mode_t'({op_top, op_low});

	// display control has no documented reset value; cleared for a defined start
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			disp_ctrl <= '0;
		end else if (wr_disp) begin
			disp_ctrl <= gcr_disp_ctrl_t'(host_req_i.wdata);
		end
	end

	// read mux follows the pointer; unknown numbers read zero
	always_comb begin
		unique case (addr_ptr)
			GCR_ADDR_CMD_CTRL:  rdata_o = cmd_ctrl;
			GCR_ADDR_OP_MODE:   rdata_o = op_mode;
			GCR_ADDR_DISP_CTRL: rdata_o = disp_ctrl;
			default:            rdata_o = 16'h0000;
		endcase
	end

	// commands wait while abort or pause is set, or while the start bit is clear;
	// a held command is not dropped, it waits for the gate to open
	assign cmd_allowed = !cmd_ctrl.abort_bit && !cmd_ctrl.pause_bit && op_mode.run_bit;

	// drawing and display share the start bit, so clearing it freezes both at once
	assign engines_run = op_mode.run_bit;

	// interrupt enables in source order, command error at the top
	assign irq_sources = {cmd_ctrl.command_error_irq_en, cmd_ctrl.area_detect_irq_en,
		cmd_ctrl.command_end_irq_en, cmd_ctrl.light_pen_irq_en,
		cmd_ctrl.read_queue_full_irq_en, cmd_ctrl.read_queue_ready_irq_en,
		cmd_ctrl.write_queue_ready_irq_en, cmd_ctrl.write_queue_empty_irq_en};

	// dma controls travel together so the engine never sees half an update
	assign dma_modes = {cmd_ctrl.data_dma_mode, cmd_ctrl.command_dma_mode,
		cmd_ctrl.dma_request_control};

	// only the four-word code is decoded here; other codes pass through unchanged
	assign step_words = (op_mode.display_addr_increment == GCR_GAI_PLUS4) ?
		GCR_GAI_STEP4 : op_mode.display_addr_increment;

	// ram bit clear means dynamic memory, which needs refresh cycles
	assign dram_refresh = !op_mode.static_ram_mode;

	// cross hair needs a cursor skew; with none the cursor cannot be aligned
	assign crosshair_allowed = |op_mode.cursor_skew;

	// a two-bit screen enable counts as on when either bit is set
	assign screens_on = {disp_ctrl.base_screen_enable, |disp_ctrl.upper_screen_enable,
		|disp_ctrl.lower_screen_enable, |disp_ctrl.window_screen_enable};

	// gather decoded controls for the engines downstream
	always_comb begin
		ctrl_o.cmd_run         = cmd_allowed;
		ctrl_o.draw_run        = engines_run;
		ctrl_o.display_run     = engines_run;
		ctrl_o.data_dma        = dma_modes[2];
		ctrl_o.command_dma     = dma_modes[1];
		ctrl_o.dma_req_en      = dma_modes[0];
		ctrl_o.irq_en          = irq_sources;
		ctrl_o.pixel_bits      = cmd_ctrl.pixel_depth_select;
		ctrl_o.addr_step       = step_words;
		ctrl_o.interleave      = (op_mode.access_mode_select == GCR_ACM_INTERLEAVE);
		ctrl_o.interlace_sv    = (op_mode.scan_mode_select == GCR_RSM_INTERLACE_SV);
		ctrl_o.refresh_en      = dram_refresh;
		ctrl_o.crosshair_ok    = crosshair_allowed;
		ctrl_o.window_prefetch = op_mode.window_smooth_scroll;
		ctrl_o.display_first   = !op_mode.access_priority;
		ctrl_o.master_timing   = op_mode.master_mode;
		ctrl_o.screen_on       = screens_on;
	end

	// blanking is the union of horizontal and vertical flyback
	assign blank_now = hblank_i || vblank_i;

	// blanking delayed by the display skew
	gcr_skew_tap #(
		.DEPTH(4)
	) blank_skew_u (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.sig_i  (blank_now),
		.skew_i (op_mode.blank_skew),
		.tap_o  (blank_tap)
	);

	// window flag shares the display skew so both enables stay aligned
	gcr_skew_tap #(
		.DEPTH(4)
	) win_skew_u (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.sig_i  (window_active_i),
		.skew_i (op_mode.blank_skew),
		.tap_o  (win_tap)
	);

	// first cursor delayed by the cursor skew
	gcr_skew_tap #(
		.DEPTH(4)
	) curs_a_skew_u (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.sig_i  (cursor_a_i),
		.skew_i (op_mode.cursor_skew),
		.tap_o  (curs_a_tap)
	);

	// second cursor delayed by the cursor skew
	gcr_skew_tap #(
		.DEPTH(4)
	) curs_b_skew_u (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.sig_i  (cursor_b_i),
		.skew_i (op_mode.cursor_skew),
		.tap_o  (curs_b_tap)
	);

	// display enables: combined blanking drives only the first output;
	// skew lengthens the back porch at the cost of the front porch
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			display_enable_out_a_o <= 1'b0;
			display_enable_out_b_o <= 1'b0;
		end else if (disp_ctrl.combined_blanking) begin
			display_enable_out_a_o <= !blank_tap && op_mode.run_bit;
			display_enable_out_b_o <= 1'b0;
		end else begin
			display_enable_out_a_o <= !blank_tap && !win_tap && op_mode.run_bit;
			display_enable_out_b_o <= !blank_tap && win_tap && op_mode.run_bit;
		end
	end

	// cursor outputs follow their own skew, independent of the display skew
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cursor_out_a_o <= 1'b0;
			cursor_out_b_o <= 1'b0;
		end else begin
			cursor_out_a_o <= curs_a_tap;
			cursor_out_b_o <= curs_b_tap;
		end
	end

	// attribute byte is driven only in horizontal flyback, zero otherwise
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			attribute_o <= 8'h00;
		end else begin
			attribute_o <= hblank_i ? disp_ctrl.user_attribute_byte : 8'h00;
		end
	end

endmodule

// one skew delay line; used for blanking, window and both cursors
module gcr_skew_tap
	import gcr_pkg::*;
#(
	parameter int DEPTH = 4
)
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       sig_i,
	input  wire logic [1:0] skew_i,
	output logic            tap_o
);

	logic [DEPTH-1:0] pipe;

	// shift every clock; reset empties the line so no stale edge leaks out
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pipe <= '0;
		end else begin
			pipe <= {pipe[DEPTH-2:0], sig_i};
		end
	end

	// a skew of n picks stage n; zero is the first stage, the base delay of every path
	assign tap_o = pipe[skew_i];

endmodule

/* File: testbench/gcr_control_regs_assertions.sv */
`timescale 1ns/1ps
module gcr_control_regs_chk
	import gcr_pkg::*;
(
	input wire logic          clk_i,
	input wire logic          rst_i,
	input wire gcr_host_req_t host_req_i,
	input wire logic          hblank_i,
	input wire logic          vblank_i,
	input wire logic          window_active_i,
	input wire logic          cursor_a_i,
	input wire logic          cursor_b_i,
	input wire logic [15:0]   rdata_o,
	input wire gcr_ctrl_t     ctrl_o,
	input wire logic [7:0]    attribute_o,
	input wire logic          display_enable_out_a_o,
	input wire logic          display_enable_out_b_o,
	input wire logic          cursor_out_a_o,
	input wire logic          cursor_out_b_o
);
	logic [7:0]  ptr;
	logic [15:0] cc;
	logic [15:0] om;
	logic [15:0] dc;
	logic [1:0]  up;
	// shadow of pointer and registers; mode low bits survive reset on purpose
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ptr <= 8'h00;
			cc <= GCR_CMD_CTRL_RESET;
			om[15:14] <= 2'h0;
			dc <= 16'h0000;
			up <= 2'h0;
		end else begin
			if (host_req_i.addr_wr) ptr <= host_req_i.addr;
			if (host_req_i.data_wr && ptr == GCR_ADDR_CMD_CTRL) cc <= host_req_i.wdata;
			if (host_req_i.data_wr && ptr == GCR_ADDR_OP_MODE) om <= host_req_i.wdata;
			if (host_req_i.data_wr && ptr == GCR_ADDR_DISP_CTRL) dc <= host_req_i.wdata;
			if (up != 2'h3) up <= up + 2'h1;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_cmd_gate: assert property (ctrl_o.cmd_run |-> !cc[15] && !cc[14] && om[14])
		else $error("commands run while held");
	a_cmd_decode: assert property (ctrl_o.irq_en == cc[7:0] && ctrl_o.pixel_bits == cc[10:8]
		&& {ctrl_o.data_dma, ctrl_o.command_dma, ctrl_o.dma_req_en} == cc[13:11]) else $error("command decode wrong");
	a_run_gate: assert property ((ctrl_o.draw_run || ctrl_o.display_run) |-> om[14])
		else $error("activity without run bit");
	a_mode_scan: assert property (host_req_i.data_wr && ptr == GCR_ADDR_OP_MODE |=>
		ctrl_o.interlace_sv == (om[1:0] == GCR_RSM_INTERLACE_SV) && ctrl_o.interleave == (om[3:2] == GCR_ACM_INTERLEAVE)
		&& ctrl_o.refresh_en == !om[7] && ctrl_o.master_timing == om[15]) else $error("mode decode wrong");
	a_mode_fetch: assert property (host_req_i.data_wr && ptr == GCR_ADDR_OP_MODE |=>
		ctrl_o.addr_step == (om[6:4] == GCR_GAI_PLUS4 ? GCR_GAI_STEP4 : om[6:4]) && ctrl_o.crosshair_ok == (om[11:10] != 2'h0)
		&& ctrl_o.window_prefetch == om[12] && ctrl_o.display_first == !om[13]) else $error("fetch decode wrong");
	a_read_back: assert property (ptr != GCR_ADDR_OP_MODE |->
		rdata_o == (ptr == GCR_ADDR_CMD_CTRL ? cc : (ptr == GCR_ADDR_DISP_CTRL ? dc : 16'h0000))) else $error("read data wrong");
	a_attr_flyback: assert property (attribute_o == ($past(hblank_i) ? $past(dc[7:0]) : 8'h00))
		else $error("attribute byte wrong");
	a_cursor_pipe: assert property (up == 2'h3 && om[11:10] == 2'h0 && $past(om[11:10], 2) == 2'h0
		|-> cursor_out_a_o == $past(cursor_a_i, 2)) else $error("cursor delay wrong");
	a_blank_combined: assert property (dc[15] [*6] |-> !display_enable_out_b_o)
		else $error("second enable active in combined mode");
endmodule
bind gcr_control_regs gcr_control_regs_chk chk_u (.*);

/* File: testbench/gcr_host_model.sv */
`timescale 1ns/1ps
module gcr_host_model
	import gcr_pkg::*;
(
	input  wire logic    clk_i,
	input  wire logic [15:0] rdata_i,
	output gcr_host_req_t req_o
);
	// pointer is reloaded before every access since it never advances
	task automatic point(input logic [7:0] a);
		@(posedge clk_i);
		req_o.addr_wr <= 1'b1;
		req_o.addr <= a;
		@(posedge clk_i);
		req_o.addr_wr <= 1'b0;
		req_o.addr <= ~a; // released lines show garbage
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		point(a);
		req_o.data_wr <= 1'b1;
		req_o.wdata <= d;
		@(posedge clk_i);
		req_o.data_wr <= 1'b0;
		req_o.wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		point(a);
		@(negedge clk_i);
		d = rdata_i;
	endtask
	initial req_o = '0;
endmodule

/* File: testbench/test_gcr_control_regs.sv */
`timescale 1ns/1ps
module test_gcr_control_regs
	import gcr_pkg::*;
;
	logic          clk_i, rst_i, hblank_i, vblank_i, window_active_i, cursor_a_i, cursor_b_i;
	logic          da, db, ca, cb;
	gcr_host_req_t req;
	gcr_ctrl_t     ctrl_o;
	logic [15:0]   rdata_o, v;
	logic [7:0]    attribute_o;
	int            error_cnt = 0, tests_run = 0, cyc = 0;
	gcr_host_model host_u (.clk_i(clk_i), .rdata_i(rdata_o), .req_o(req));
	gcr_control_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .host_req_i(req), .hblank_i(hblank_i), .vblank_i(vblank_i),
		.window_active_i(window_active_i), .cursor_a_i(cursor_a_i), .cursor_b_i(cursor_b_i), .rdata_o(rdata_o),
		.ctrl_o(ctrl_o), .attribute_o(attribute_o), .display_enable_out_a_o(da), .display_enable_out_b_o(db),
		.cursor_out_a_o(ca), .cursor_out_b_o(cb));
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	// timing inputs other than hblank_i keep moving so the output pipes carry traffic; also the hang guard
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		{cursor_b_i, window_active_i, vblank_i, cursor_a_i} <= cyc[3:0];
		if (cyc == 3000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		tests_run++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wc(input logic [7:0] a, input logic [15:0] d);
		host_u.wr(a, d);
		host_u.rd(a, v);
		chk("readback", v, d);
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		{rst_i, hblank_i} = 2'h2;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		host_u.rd(GCR_ADDR_CMD_CTRL, v);
		chk("cmd reset", v, GCR_CMD_CTRL_RESET);
		host_u.rd(GCR_ADDR_OP_MODE, v);
		chk("mode top", {14'h0, v[15:14]}, {14'h0, GCR_OP_MODE_TOP_RESET});
		chk("cmd halted", ctrl_o.cmd_run, 1'b0);
		chk("draw halted", ctrl_o.draw_run, 1'b0);
		host_u.wr(8'h08, 16'hFFFF);
		host_u.rd(8'h08, v);
		chk("unmapped", v, 16'h0000);
		$display("test reset done");
		wc(GCR_ADDR_CMD_CTRL, 16'h0300);
		wc(GCR_ADDR_OP_MODE, 16'hC0AB);
		wc(GCR_ADDR_DISP_CTRL, 16'hC000);
		chk("screens", ctrl_o.screen_on, 4'h8);
		chk("enable b", db, 1'b0);
		chk("depth", ctrl_o.pixel_bits, GCR_DEPTH_8BPP);
		chk("step", ctrl_o.addr_step, GCR_GAI_STEP4);
		chk("modes", {ctrl_o.interleave, ctrl_o.interlace_sv, ctrl_o.refresh_en}, 3'h6);
		chk("runs", {ctrl_o.master_timing, ctrl_o.draw_run, ctrl_o.cmd_run}, 3'h7);
		wc(GCR_ADDR_CMD_CTRL, 16'h7BFF);
		chk("paused", ctrl_o.cmd_run, 1'b0);
		chk("irq", ctrl_o.irq_en, 8'hFF);
		chk("dma", {ctrl_o.data_dma, ctrl_o.command_dma, ctrl_o.dma_req_en}, 3'h7);
		wc(GCR_ADDR_OP_MODE, 16'h3110);
		chk("no crosshair", ctrl_o.crosshair_ok, 1'b0);
		wc(GCR_ADDR_OP_MODE, 16'h3D10);
		chk("fetch", {ctrl_o.crosshair_ok, ctrl_o.window_prefetch, ctrl_o.display_first}, 3'h6);
		chk("slave", {ctrl_o.master_timing, ctrl_o.draw_run, ctrl_o.refresh_en}, 3'h1);
		$display("test decode done");
		wc(GCR_ADDR_DISP_CTRL, 16'hC0A5);
		@(posedge clk_i) hblank_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		@(negedge clk_i) chk("attr flyback", attribute_o, 8'hA5);
		@(posedge clk_i) hblank_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		@(negedge clk_i) chk("attr idle", attribute_o, 8'h00);
		wc(GCR_ADDR_OP_MODE, 16'hD110);
		@(posedge clk_i) rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		host_u.rd(GCR_ADDR_OP_MODE, v);
		chk("mode kept", v, 16'h1110);
		chk("dark", {da, db}, 2'h0);
		host_u.rd(GCR_ADDR_CMD_CTRL, v);
		chk("cmd reset again", v, GCR_CMD_CTRL_RESET);
		repeat (8) @(posedge clk_i);
		$display("test attribute and reset done");
		report_and_stop();
	end
endmodule
